/* hw/adcss_conv_if.sv */
// Request and answer between the sequencer and the result formatter.
// Assumes both ends run on the same pclk.
`timescale 1ns/100ps
interface adcss_conv_if;
  logic       valid;     // Raw sample taken this cycle
  logic [9:0] raw;       // Raw unsigned 10-bit code
  logic       justify;   // 1 right justified
  logic       signed_s;  // 1 signed request
  logic       lowres;    // 1 eight-bit resolution
  logic [15:0] word;     // Formatted result

  modport seq (output valid, raw, justify, signed_s, lowres, input word);
  modport fmt (input valid, raw, justify, signed_s, lowres, output word);
endinterface : adcss_conv_if

/* hw/adcss_format.sv */
// Result formatter: places a raw code on the 16-bit result bus.
// Assumes a raw 10-bit unsigned code; 8-bit mode uses its upper 8 bits.
`timescale 1ns/100ps
module adcss_format (
  input  wire logic pclk,    // Bus clock
  input  wire logic presetn, // Async reset, active low
  adcss_conv_if.fmt cv       // Conversion data
);

  // Right justified data ignores the sign select
  wire logic use_sign = cv.signed_s & ~cv.justify; // see (R4)
  logic [15:0] word_r;
  logic [15:0] word_nxt;

  // Mapping by resolution and justification
  always_comb begin
    word_nxt = 16'h0000;
    if (cv.lowres) begin
      if (cv.justify) word_nxt = {8'h00, cv.raw[9:2]};             // see (R11) (R2)
      else word_nxt = {cv.raw[9] ^ use_sign, cv.raw[8:2], 8'h00};  // see (R11) (R3)
    end else begin
      if (cv.justify) word_nxt = {6'h00, cv.raw};                  // see (R11) (R2)
      else word_nxt = {cv.raw[9] ^ use_sign, cv.raw[8:0], 6'h00};  // see (R11) (R3)
    end
  end

  // Result register, loaded with the mapped word on each finished sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) word_r <= 16'h0000;
    else if (cv.valid) word_r <= word_nxt;
  end

  assign cv.word = word_r;

endmodule : adcss_format

/* hw/adcss_pkg.sv */
// Constants, register map and types for the conversion sequence start control.
// Assumes an APB master on pclk; sample completion comes from the analog side.
// Operation
// (R1) Any write to the sequence start register aborts the running sequence and starts a new one.
// (R2) Bit 7 clear gives left justified results, set gives right justified results.
// (R3) Bit 6 clear gives unsigned results, set gives two's complement signed results.
// (R4) Right justified results are always unsigned whatever bit 6 says.
// (R5) Bit 5 clear runs one sequence and stops, set repeats sequences back to back.
// (R6) Bit 4 clear converts only the coded input for every conversion of the sequence.
// (R7) Bit 4 set steps across inputs, as many as the sequence length value; the code runs one input when that value is zero.
// (R8) Bits 3:0 name the single input, or the first input in multi-channel mode.
// (R9) Each next input is the code plus one, and after the wrap limit input comes input zero.
// (R10) A start above the wrap limit counts up to input fifteen before its first wrap to zero.
// (R11) Results map to bits 15:8, 7:0, 15:6 or 9:0 by resolution and justification.
// (R12) The channel code is plain binary, 0000 for input zero up to 1111 for input fifteen.
// (R13) The done flag sets at the end of every completed sequence and a start write clears it.
package adcss_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_START   = 12'h000;
  localparam logic [11:0] OFS_WRAP    = 12'h004;
  localparam logic [11:0] OFS_CONFIG  = 12'h008;
  localparam logic [11:0] OFS_STATUS  = 12'h00c;
  localparam logic [11:0] OFS_IRQ_ST  = 12'h010;
  localparam logic [11:0] OFS_IRQ_MSK = 12'h014;
  localparam logic [11:0] OFS_RESULT  = 12'h018;

  // Start register fields
  localparam int BIT_JUSTIFY = 7;
  localparam int BIT_SIGNED  = 6;
  localparam int BIT_CONT    = 5;
  localparam int BIT_MULTI   = 4;

  // Config register fields: sequence length in 3:0, low resolution in 8
  localparam int BIT_LOWRES  = 8;

  // Reset values
  localparam logic [7:0] RST_START  = 8'h00;
  localparam logic [3:0] RST_WRAP   = 4'hf;
  localparam logic [3:0] RST_SEQLEN = 4'h4;
  localparam logic [1:0] RST_MASK   = 2'h0;

  // Interrupt status bits
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ABORT = 1;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQ,
    ST_WAIT
  } adcss_state_t;

endpackage : adcss_pkg

/* hw/adcss_top.sv */
// Sequence start control with APB slave, channel stepping and result formatting.
// Assumes the analog side answers each sample request with one done pulse.
`timescale 1ns/100ps
module adcss_top (
  input  wire logic        pclk,        // Bus clock, 100 MHz
  input  wire logic        presetn,     // Async reset, active low
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB enable
  input  wire logic        pwrite,      // APB direction
  input  wire logic [11:0] paddr,       // APB byte address
  input  wire logic [31:0] pwdata,      // APB write data
  output logic      [31:0] prdata,      // APB read data
  output logic             pready,      // APB ready
  output logic             pslverr,     // APB error
  output logic             sample_req,  // One-cycle sample request
  output logic      [3:0]  sample_chan, // Input being converted
  output logic             abort,       // One-cycle abort pulse
  input  wire logic        sample_done, // Sample finished pulse
  input  wire logic [9:0]  sample_code, // Raw code with sample_done
  output logic             seq_busy,    // Sequence in progress
  output logic             irq          // Level interrupt
);

  adcss_conv_if cv ();

  adcss_pkg::adcss_state_t state_r;
  logic [7:0]  start_r;
  logic [3:0]  wrap_r;
  logic [3:0]  seqlen_r;
  logic        lowres_r;
  logic [3:0]  chan_r;
  logic [3:0]  first_r;
  logic [3:0]  count_r;
  logic        done_flag_r;
  logic [1:0]  irq_st_r;
  logic [1:0]  irq_msk_r;
  logic        pending_r;

  // Bus phase decode
  wire logic acc   = psel & penable;
  wire logic wr    = acc & pwrite;
  wire logic rd    = acc & ~pwrite;
  wire logic wr_st = wr & (paddr == adcss_pkg::OFS_START);
  wire logic last  = (count_r == seqlen_r - 4'h1) | (seqlen_r == 4'h0);
  wire logic fin   = (state_r == adcss_pkg::ST_WAIT) & sample_done & ~wr_st;
  wire logic seq_end = fin & last;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == adcss_pkg::OFS_START) | (a == adcss_pkg::OFS_WRAP) |
             (a == adcss_pkg::OFS_CONFIG) | (a == adcss_pkg::OFS_STATUS) |
             (a == adcss_pkg::OFS_IRQ_ST) | (a == adcss_pkg::OFS_IRQ_MSK) |
             (a == adcss_pkg::OFS_RESULT);
  endfunction : mapped

  // Next input: plus one, wrapping after the limit or after fifteen
  function automatic logic [3:0] next_chan(input logic [3:0] c, input logic [3:0] w);
    next_chan = (c == w) ? 4'h0 : c + 4'h1; // see (R9) (R10) (R12)
  endfunction : next_chan

  // Zero wait state slave
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped(paddr);

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r   <= adcss_pkg::RST_START;
      wrap_r    <= adcss_pkg::RST_WRAP;
      seqlen_r  <= adcss_pkg::RST_SEQLEN;
      lowres_r  <= 1'b0;
      irq_msk_r <= adcss_pkg::RST_MASK;
    end else if (wr) begin
      if (paddr == adcss_pkg::OFS_START) start_r <= pwdata[7:0];
      if (paddr == adcss_pkg::OFS_WRAP) wrap_r <= pwdata[3:0];
      if (paddr == adcss_pkg::OFS_CONFIG) begin
        seqlen_r <= pwdata[3:0];
        lowres_r <= pwdata[adcss_pkg::BIT_LOWRES];
      end
      if (paddr == adcss_pkg::OFS_IRQ_MSK) irq_msk_r <= pwdata[1:0];
    end
  end

  // Sequencer; a start write restarts from any state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= adcss_pkg::ST_IDLE;
      chan_r  <= 4'h0;
      first_r <= 4'h0;
      count_r <= 4'h0;
    end else if (wr_st) begin
      state_r <= adcss_pkg::ST_REQ;         // see (R1)
      chan_r  <= pwdata[3:0];               // see (R8)
      first_r <= pwdata[3:0];
      count_r <= 4'h0;
    end else begin
      unique case (state_r)
        adcss_pkg::ST_IDLE: state_r <= adcss_pkg::ST_IDLE;
        adcss_pkg::ST_REQ:  state_r <= adcss_pkg::ST_WAIT;
        adcss_pkg::ST_WAIT: begin
          if (sample_done) begin
            if (last) begin
              count_r <= 4'h0;
              chan_r  <= first_r;
              state_r <= start_r[adcss_pkg::BIT_CONT] ? adcss_pkg::ST_REQ
                                                      : adcss_pkg::ST_IDLE; // see (R5)
            end else begin
              count_r <= count_r + 4'h1;
              state_r <= adcss_pkg::ST_REQ;
              if (start_r[adcss_pkg::BIT_MULTI]) chan_r <= next_chan(chan_r, wrap_r); // see (R7)
              // Single mode keeps the same input
            end                               // see (R6)
          end
        end
        // The fourth code of the two-bit state is unused; fall back to idle
        default: state_r <= adcss_pkg::ST_IDLE;
      endcase
    end
  end

  // Abort pulse only when a running sequence is cut
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) abort <= 1'b0;
    else abort <= wr_st & (state_r != adcss_pkg::ST_IDLE); // see (R1)
  end

  assign sample_req  = (state_r == adcss_pkg::ST_REQ);
  assign sample_chan = chan_r;
  assign seq_busy    = (state_r != adcss_pkg::ST_IDLE);

  // Done flag; a start write clears it, and cannot coincide with seq_end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) done_flag_r <= 1'b0;
    else if (seq_end) done_flag_r <= 1'b1; // see (R13)
    else if (wr_st) done_flag_r <= 1'b0;   // see (R13)
  end

  // Sticky interrupt status, cleared by read; set wins over clear
  wire logic rd_irq = rd & (paddr == adcss_pkg::OFS_IRQ_ST);
  wire logic [1:0] ev = {abort, seq_end};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_st_r <= 2'h0;
    else irq_st_r <= (rd_irq ? 2'h0 : irq_st_r) | ev;
  end

  assign irq = |(irq_st_r & irq_msk_r);

  // Result formatter link; justify and sign come from the live start register, resolution from the config register
  assign cv.valid    = fin;
  assign cv.raw      = sample_code;
  assign cv.justify  = start_r[adcss_pkg::BIT_JUSTIFY];
  assign cv.signed_s = start_r[adcss_pkg::BIT_SIGNED];
  assign cv.lowres   = lowres_r;

  adcss_format u_fmt (
    .pclk    (pclk),
    .presetn (presetn),
    .cv      (cv)
  );

  // Pending bit marks an unread result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pending_r <= 1'b0;
    else if (fin) pending_r <= 1'b1;
    else if (rd & (paddr == adcss_pkg::OFS_RESULT)) pending_r <= 1'b0;
  end

  // Read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      unique case (paddr)
        adcss_pkg::OFS_START:   prdata = {24'h000000, start_r};
        adcss_pkg::OFS_WRAP:    prdata = {28'h0000000, wrap_r};
        adcss_pkg::OFS_CONFIG:  prdata = {23'h000000, lowres_r, 4'h0, seqlen_r};
        adcss_pkg::OFS_STATUS:  prdata = {16'h0000, 3'h0, pending_r, count_r,
                                          chan_r, 2'h0, seq_busy, done_flag_r};
        adcss_pkg::OFS_IRQ_ST:  prdata = {30'h00000000, irq_st_r};
        adcss_pkg::OFS_IRQ_MSK: prdata = {30'h00000000, irq_msk_r};
        adcss_pkg::OFS_RESULT:  prdata = {16'h0000, cv.word};
        default:                prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule : adcss_top

/* testbench/adcss_sva.sv */
// Port checker for the sequence start control.
// Assumes a bind to adcss_top, all on pclk.
`timescale 1ns/100ps
module adcss_sva (
  input wire logic        pclk,        // Clock
  input wire logic        presetn,     // Reset
  input wire logic        psel,        // Select
  input wire logic        penable,     // Enable
  input wire logic        pwrite,      // Write
  input wire logic [11:0] paddr,       // Address
  input wire logic [31:0] prdata,      // Read data
  input wire logic        pready,      // Ready
  input wire logic        pslverr,     // Error
  input wire logic        sample_req,  // Request
  input wire logic        abort,       // Abort
  input wire logic        sample_done, // Done
  input wire logic        seq_busy     // Busy
);
  // Access and start write at a sampling edge
  wire acc = psel && penable;
  wire st  = acc && pwrite && paddr == adcss_pkg::OFS_START;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_req: assert property (st |=> sample_req)
    else $error("no request after start");
  a_abort_cut: assert property (st && seq_busy |=> abort)
    else $error("running sequence not aborted");
  a_abort_idle: assert property (st && !seq_busy |=> !abort)
    else $error("abort with nothing running");
  a_abort_once: assert property (abort |=> !abort)
    else $error("abort longer than a cycle");
  a_req_busy: assert property (sample_req |-> seq_busy)
    else $error("request while idle");
  a_req_wait: assert property (sample_req && !st |=> !sample_req)
    else $error("request not a pulse");
  a_done_next: assert property (sample_done && seq_busy && !st |=> sample_req || !seq_busy)
    else $error("sequence stalled after sample");
  a_err_unmap: assert property (acc && paddr > 12'h018 |-> pslverr)
    else $error("unmapped access accepted");
  a_read_idle: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read");
  a_ready_high: assert property (acc |-> pready)
    else $error("ready low in access");
endmodule : adcss_sva

/* testbench/testbench.sv */
// Self-checking bench for the sequence start control.
// Assumes adcss_top; the bench is bus master and analog side.
`timescale 1ns/100ps
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        sample_done = 0, auto = 1, pready, pslverr, sample_req, abort, seq_busy, irq, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [9:0]  sample_code = 0;
  logic [3:0]  sample_chan, c, w, len;
  logic [3:0]  chans[$];
  logic [7:0]  s;
  logic        lr;
  int          bad_count = 0, comparisons = 0;

  always #5 pclk = ~pclk;
  adcss_top i_dut (.*);

  // Analog side answers next cycle; a start write cancels the answer
  always @(posedge pclk) begin
    sample_done <= sample_req === 1'b1 && auto && !(penable && pwrite && paddr == 12'h0);
    if (sample_req === 1'b1 && auto && !(penable && pwrite && paddr == 12'h0)) begin
      sample_code <= 10'($urandom);
      chans.push_back(sample_chan);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && k++ < 20);
    if (pready !== 1'b1) bad_count++;
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Waits one edge first so the start has landed
  task automatic idle();
    int k;
    k = 0;
    @(posedge pclk);
    while (seq_busy !== 1'b0 && k++ < 200) @(posedge pclk);
    if (seq_busy !== 1'b0) bad_count++;
  endtask : idle

  // Expected result word; sign flip only when left justified
  function automatic logic [31:0] fmt(logic [9:0] v, logic rj, logic sg, logic lo);
    logic [15:0] r;
    r = lo ? {v[9:2], 8'h00} : {v, 6'h00};
    if (rj) r = lo ? {8'h00, v[9:2]} : {6'h00, v};
    else if (sg) r[15] = ~r[15];
    return {16'h0, r};
  endfunction : fmt

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    #300000;
    bad_count++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h68d68581));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    chk(q, 0);
    apb(0, 12'h004, 0);
    chk(q, 32'hf);
    apb(0, 12'h008, 0);
    chk(q, 32'h4);
    apb(1, 12'h01c, 5);
    chk(err, 1);
    $display("test reset end");
    // Two wrap corners, then random single and multi runs
    for (int i = 0; i < 12; i++) begin
      s   = 8'($urandom) & 8'hdf;
      w   = i < 2 ? 4'h5 : 4'($urandom);
      len = i < 2 ? 4'h6 + 4'(2 * i) : 4'($urandom);
      lr  = 1'($urandom);
      if (i < 2) s = i ? 8'h19 : 8'h13;
      chans.delete();
      apb(1, 12'h004, 32'(w));
      apb(1, 12'h008, {lr, 4'h0, len});
      apb(1, 12'h000, 32'(s));
      idle();
      chk(32'(chans.size()), len ? len : 1);
      c = s[3:0];
      foreach (chans[j]) begin
        chk(chans[j], c);
        if (s[4]) c = c == w ? 4'h0 : c + 4'h1;
      end
      apb(0, 12'h00c, 0);
      chk(q[0], 1);
      chk(q[12], 1);
      apb(0, 12'h018, 0);
      chk(q, fmt(sample_code, s[7], s[6], lr));
    end
    $display("test sequences end");
    // Masked event, unmasked, then cleared by the read
    chk(irq, 0);
    apb(1, 12'h014, 1);
    @(negedge pclk);
    chk(irq, 1);
    apb(0, 12'h010, 0);
    chk(q[0], 1);
    @(negedge pclk);
    chk(irq, 0);
    $display("test irq end");
    // Silent analog side so the second start cuts a live sequence
    auto <= 1'b0;
    apb(1, 12'h000, 2);
    apb(0, 12'h00c, 0);
    chk(q[1:0], 2'b10);
    apb(1, 12'h000, 3);
    @(negedge pclk);
    chk(abort, 1);
    apb(0, 12'h010, 0);
    chk(q[1], 1);
    auto <= 1'b1;
    apb(1, 12'h000, 4);
    idle();
    $display("test abort end");
    // Continuous runs keep going until a single-shot start
    chans.delete();
    apb(1, 12'h008, 2);
    apb(1, 12'h000, 8'h27);
    repeat (40) @(posedge pclk);
    chk(chans.size() > 4, 1);
    apb(0, 12'h00c, 0);
    chk(q[1:0], 2'b11);
    apb(1, 12'h000, 7);
    idle();
    chk(seq_busy, 0);
    $display("test continuous end");
    end_of_test();
  end
endmodule : testbench

bind adcss_top adcss_sva i_sva (.*);
